// ==== nvc_defines.svh ====
// Constants for the nonvolatile SRAM store/recall host controller.
// Assumes a 125 MHz system clock; times are given in nanoseconds.
`ifndef NVC_DEFINES_SVH
`define NVC_DEFINES_SVH
`define NVC_CLK_PERIOD_NS   8
`define NVC_ADDR_W          21
`define NVC_DATA_W          16
`define NVC_SEQ_LO          2
`define NVC_SEQ_HI          14
`define NVC_SEQ_A1          21'h004e38
`define NVC_SEQ_A2          21'h00b1c7
`define NVC_SEQ_A3          21'h0083e0
`define NVC_SEQ_A4          21'h007c1f
`define NVC_SEQ_A5          21'h00703f
`define NVC_SEQ_STORE       21'h008fc0
`define NVC_SEQ_RECALL      21'h004c63
`define NVC_SEQ_AS_OFF      21'h008b45
`define NVC_SEQ_AS_ON       21'h004b46
`define NVC_STROBE_NS       48
`define NVC_STROBE_CYC      ((`NVC_STROBE_NS + `NVC_CLK_PERIOD_NS - 1) / `NVC_CLK_PERIOD_NS)
`define NVC_PIN_STORE_NS    40
`define NVC_PIN_STORE_CYC   ((`NVC_PIN_STORE_NS + `NVC_CLK_PERIOD_NS - 1) / `NVC_CLK_PERIOD_NS)
`define NVC_CNT_W           24
`endif

// ==== nvc_dev_model.sv ====
// Behavioural nonvolatile SRAM device facing the host controller.
// Assumes the bench resolves the busy pin with a pull-up.
`timescale 1ns/1ps
`include "nvc_defines.svh"
module nvc_dev_model #(
  parameter int STORE_T  = 200,
  parameter int RECALL_T = 100
) (
  input wire logic        clk_sys, sramCeN, sramOeN, sramWeN, pinN, supplyOk,
  input wire logic [20:0] sramAddr,
  input wire logic [15:0] sramDqOut,
  output logic     [15:0] sramDqIn,
  output logic            busyLow
);
  logic [15:0] m [256] = '{default: 16'h0};
  logic [15:0] nv [256] = '{default: 16'h0};
  logic [20:0] ld [5] = '{`NVC_SEQ_A1, `NVC_SEQ_A2, `NVC_SEQ_A3, `NVC_SEQ_A4, `NVC_SEQ_A5};
  logic latchW = 1'b0, autoOn = 1'b1, drive = 1'b1, ceQ = 1'b1, rclPend = 1'b0;
  int idx = 0, cnt = RECALL_T;
  wire sel = ceQ && !sramCeN && pinN && supplyOk && cnt == 0;
  // The brief high drive after a store cannot show on a pulled-up wire
  assign busyLow = cnt != 0 && drive;
  // Released bus flips each half cycle so stale data never matches
  assign sramDqIn = !sramCeN && !sramOeN && cnt == 0 ? m[sramAddr[7:0]] : {8{clk_sys, !clk_sys}};
  function automatic logic hit(input logic [20:0] s);
    return sramAddr[14:2] == s[14:2];
  endfunction
  task automatic start(input int t, input logic st, drv);
    cnt <= t;
    drive <= drv;
    if (st) nv <= m;
    else m <= nv;
  endtask
  always @(posedge clk_sys) begin
    ceQ <= sramCeN;
    if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) latchW <= 1'b0;
    end else if (!supplyOk) begin
      // A supply dip seen while no store or recall runs leaves a recall pending, store or not
      rclPend <= 1'b1;
      if (autoOn && latchW) start(STORE_T, 1'b1, 1'b1);
    end else if (rclPend) begin
      rclPend <= 1'b0;
      start(RECALL_T, 1'b0, 1'b1);
    end else if (!pinN && latchW) start(STORE_T, 1'b1, 1'b1);
    else if (sel && !sramWeN) begin
      m[sramAddr[7:0]] <= sramDqOut;
      latchW <= 1'b1;
      idx <= 0;
    end else if (sel && idx < 5) idx <= hit(ld[idx]) ? idx + 1 : int'(hit(ld[0]));
    else if (sel) begin
      idx <= 0;
      if (hit(`NVC_SEQ_STORE)) start(STORE_T, 1'b1, 1'b1);
      if (hit(`NVC_SEQ_RECALL)) start(RECALL_T, 1'b0, 1'b0);
      if (hit(`NVC_SEQ_AS_OFF)) autoOn <= 1'b0;
      if (hit(`NVC_SEQ_AS_ON)) autoOn <= 1'b1;
    end
  end
endmodule : nvc_dev_model

// ==== nvc_host_ctrl.sv ====
// Host-side controller driving a nonvolatile SRAM over its asynchronous port and busy pin.
// Assumes the busy pin wire is resolved outside with a pull-up; the store/recall times are parameters.
`timescale 1ns/1ps
`include "nvc_defines.svh"
module nvc_host_ctrl
  import nvc_pkg::*;
#(
  parameter int unsigned STORE_CYC  = 2_000_000,
  parameter int unsigned RECALL_CYC = 25_000
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // Command port
  input  wire logic                     cmdValid,
  input  nvc_pkg::nvc_cmd_t             cmdOp,
  input  wire logic [`NVC_ADDR_W-1:0]   cmdAddr,
  input  wire logic [`NVC_DATA_W-1:0]   cmdWdata,
  output logic                          cmdReady,
  output logic                          rspValid,
  output logic [`NVC_DATA_W-1:0]        rspRdata,
  output logic                          devBusy,
  // SRAM port
  output logic [`NVC_ADDR_W-1:0]        sramAddr,
  output logic                          sramCeN,
  output logic                          sramOeN,
  output logic                          sramWeN,
  output logic [`NVC_DATA_W-1:0]        sramDqOut,
  output logic                          sramDqOe,
  input  wire logic [`NVC_DATA_W-1:0]   sramDqIn,
  // Busy pin, open drain
  input  wire logic                     storeBusyNIn,
  output logic                          storeBusyNOut,
  output logic                          storeBusyNOe
);
  import nvc_pkg::*;

  typedef enum logic [2:0] {
    NVC_IDLE, NVC_STROBE, NVC_GAP, NVC_PIN, NVC_WAIT_DEV
  } nvc_state_t;

  nvc_state_t                 state_q;
  nvc_cmd_t                   op_q;
  logic [2:0]                 seqIdx_q;
  logic [`NVC_CNT_W-1:0]      cnt_q;
  logic                       busyMeta_q;
  logic                       busySync_q;

  // ****************************************
  // Busy pin synchroniser
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Reset low so no command is taken before the pin has been seen high
      busyMeta_q <= 1'b0;
      busySync_q <= 1'b0;
    end else begin
      busyMeta_q <= storeBusyNIn;
      busySync_q <= busyMeta_q;
    end
  end

  // ****************************************
  // Sequence address lookup
  // ****************************************
  function automatic logic [`NVC_ADDR_W-1:0] seqAddr(input logic [2:0] idx, input nvc_cmd_t op);
    logic [`NVC_ADDR_W-1:0] a;
    a = `NVC_SEQ_STORE;
    unique case (idx)
      3'h0: a = `NVC_SEQ_A1;
      3'h1: a = `NVC_SEQ_A2;
      3'h2: a = `NVC_SEQ_A3;
      3'h3: a = `NVC_SEQ_A4;
      3'h4: a = `NVC_SEQ_A5;
      default: begin
        if (op == NVC_CMD_RECALL) a = `NVC_SEQ_RECALL;
        else if (op == NVC_CMD_AS_OFF) a = `NVC_SEQ_AS_OFF;
        else if (op == NVC_CMD_AS_ON) a = `NVC_SEQ_AS_ON;
        else a = `NVC_SEQ_STORE;
      end
    endcase
    return a;
  endfunction : seqAddr

  // Six-read commands, as opposed to plain accesses and the pin request
  wire logic isSeq = (op_q == NVC_CMD_STORE) || (op_q == NVC_CMD_RECALL) ||
                     (op_q == NVC_CMD_AS_OFF) || (op_q == NVC_CMD_AS_ON);

  // ****************************************
  // Access sequencer
  // ****************************************
  // A sequence is issued as six uninterrupted reads; commands are refused meanwhile so
  // no foreign access can slip in and abort it.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q       <= NVC_IDLE;
      op_q          <= NVC_CMD_READ;
      seqIdx_q      <= 3'h0;
      cnt_q         <= '0;
      cmdReady      <= 1'b0;
      rspValid      <= 1'b0;
      rspRdata      <= '0;
      devBusy       <= 1'b1;
      sramAddr      <= '0;
      sramCeN       <= 1'b1;
      sramOeN       <= 1'b1;
      sramWeN       <= 1'b1;
      sramDqOut     <= '0;
      sramDqOe      <= 1'b0;
      storeBusyNOut <= 1'b0;
      storeBusyNOe  <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      unique case (state_q)
        NVC_IDLE: begin
          // Device busy during power-up recall or any store: hold off
          devBusy  <= !busySync_q;
          cmdReady <= busySync_q;
          // Ready alone qualifies the take, so a master never sees its request dropped;
          // a pin falling inside the synchroniser lag is left to the device to block
          if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            op_q     <= cmdOp;
            seqIdx_q <= 3'h0;
            devBusy  <= 1'b1;
            if (cmdOp == NVC_CMD_PIN_STORE) begin
              storeBusyNOe <= 1'b1;
              cnt_q        <= `NVC_CNT_W'(`NVC_PIN_STORE_CYC);
              state_q      <= NVC_PIN;
            end else begin
              sramCeN  <= 1'b0;
              sramWeN  <= !(cmdOp == NVC_CMD_WRITE);
              sramOeN  <= (cmdOp == NVC_CMD_WRITE);
              sramDqOe <= (cmdOp == NVC_CMD_WRITE);
              sramDqOut <= cmdWdata;
              sramAddr <= (cmdOp == NVC_CMD_READ || cmdOp == NVC_CMD_WRITE) ? cmdAddr
                          : seqAddr(3'h0, cmdOp);
              cnt_q    <= `NVC_CNT_W'(`NVC_STROBE_CYC);
              state_q  <= NVC_STROBE;
            end
          end
        end
        NVC_STROBE: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == `NVC_CNT_W'(1)) begin
            rspRdata <= sramDqIn;
            sramCeN  <= 1'b1;
            sramOeN  <= 1'b1;
            sramWeN  <= 1'b1;
            sramDqOe <= 1'b0;
            state_q  <= NVC_GAP;
          end
        end
        NVC_GAP: begin
          if (isSeq && seqIdx_q != 3'h5) begin
            seqIdx_q <= seqIdx_q + 3'h1;
            sramAddr <= seqAddr(seqIdx_q + 3'h1, op_q);
            sramCeN  <= 1'b0;
            sramOeN  <= 1'b0;
            cnt_q    <= `NVC_CNT_W'(`NVC_STROBE_CYC);
            state_q  <= NVC_STROBE;
          end else if (op_q == NVC_CMD_STORE) begin
            // Store and recall hold the host off for the device's own cycle time
            cnt_q   <= `NVC_CNT_W'(STORE_CYC);
            state_q <= NVC_WAIT_DEV;
          end else if (op_q == NVC_CMD_RECALL) begin
            cnt_q   <= `NVC_CNT_W'(RECALL_CYC);
            state_q <= NVC_WAIT_DEV;
          end else begin
            rspValid <= 1'b1;
            state_q  <= NVC_IDLE;
          end
        end
        NVC_PIN: begin
          // Long enough for the device to see it and let any write finish
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == `NVC_CNT_W'(1)) begin
            storeBusyNOe <= 1'b0;
            cnt_q        <= `NVC_CNT_W'(STORE_CYC);
            state_q      <= NVC_WAIT_DEV;
          end
        end
        NVC_WAIT_DEV: begin
          // Wait out the store or recall time, and the pin too since the device owns it
          // Waiting on the pin alone would miss a store the device has yet to start
          if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
          else if (busySync_q) begin
            rspValid <= 1'b1;
            state_q  <= NVC_IDLE;
          end
        end
        default: state_q <= NVC_IDLE;
      endcase
    end
  end
endmodule : nvc_host_ctrl

// ==== nvc_host_ctrl_asserts.sv ====
// Port checks for the store/recall host controller.
// Bound to nvc_host_ctrl; sees its ports only.
`timescale 1ns/1ps
module nvc_host_ctrl_asserts
  import nvc_pkg::*;
(
  input wire logic        clk_sys, rst_n, cmdValid, cmdReady, rspValid,
  input nvc_pkg::nvc_cmd_t cmdOp,
  input wire logic [20:0] cmdAddr, sramAddr,
  input wire logic        sramCeN, sramOeN, sramWeN, sramDqOe, devBusy,
  input wire logic        storeBusyNIn, storeBusyNOut, storeBusyNOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire take = cmdValid && cmdReady;
  wire rd = take && cmdOp == NVC_CMD_READ;
  rd_no_wr_a: assert property (!sramOeN |-> sramWeN && !sramDqOe)
    else $error("write in read");
  strobe_len_a: assert property ($fell(sramCeN) |-> !sramCeN [*6] ##1 sramCeN)
    else $error("strobe length");
  pin_blocks_a: assert property (!storeBusyNIn [*5] |-> !cmdReady)
    else $error("ready while pin low");
  pin_pulse_a: assert property ($rose(storeBusyNOe) |-> storeBusyNOe [*5] ##1 !storeBusyNOe)
    else $error("pin pulse");
  drain_only_a: assert property (storeBusyNOe |-> !storeBusyNOut)
    else $error("pin driven high");
  busy_flag_a: assert property (devBusy == !cmdReady)
    else $error("busy flag");
  rd_addr_a: assert property (rd |=> !sramCeN && !sramOeN && sramAddr == $past(cmdAddr))
    else $error("read start");
  rd_done_a: assert property (rd |-> ##8 rspValid)
    else $error("read answer");
  seq_head_a: assert property (take && cmdOp < NVC_CMD_PIN_STORE |=> sramAddr[14:2] == 13'h138e)
    else $error("sequence head");
  cover property (take && cmdOp == NVC_CMD_STORE);
  cover property (take && cmdOp == NVC_CMD_PIN_STORE);
  cover property (rd ##8 rspValid);
  cover property (!storeBusyNIn && !storeBusyNOe && cmdReady);
endmodule : nvc_host_ctrl_asserts
bind nvc_host_ctrl nvc_host_ctrl_asserts i_nvc_host_ctrl_asserts (.*);

// ==== nvc_host_ctrl_test.sv ====
// Bench for the store/recall host controller with a device model.
// Assumes design, checker and model are compiled first.
`timescale 1ns/1ps
module nvc_host_ctrl_test;
  import nvc_pkg::*;
  localparam int ST = 200, RT = 100;
  logic clk_sys = 1'b0, rst_n = 1'b0, cmdValid = 1'b0, supplyOk = 1'b1;
  nvc_cmd_t cmdOp = NVC_CMD_READ;
  logic [20:0] cmdAddr = '0, sramAddr;
  logic [15:0] cmdWdata = '0, rspRdata, sramDqOut, sramDqIn;
  logic cmdReady, rspValid, sramCeN, sramOeN, sramWeN, oe, busyLow;
  int numErrors = 0, testsRun = 0, lowCyc = 0;
  longint t0;
  wire pinN = !(oe || busyLow);
  nvc_host_ctrl #(.STORE_CYC(ST), .RECALL_CYC(RT)) i_nvc_host_ctrl (.clk_sys, .rst_n, .cmdValid, .cmdOp,
    .cmdAddr, .cmdWdata, .cmdReady, .rspValid, .rspRdata, .devBusy(), .sramAddr, .sramCeN, .sramOeN,
    .sramWeN, .sramDqOut, .sramDqOe(), .sramDqIn, .storeBusyNIn(pinN), .storeBusyNOut(), .storeBusyNOe(oe));
  nvc_dev_model #(.STORE_T(ST), .RECALL_T(RT)) i_nvc_dev_model (.clk_sys, .sramCeN, .sramOeN, .sramWeN,
    .pinN, .supplyOk, .sramAddr, .sramDqOut, .sramDqIn, .busyLow);
  initial forever #4 clk_sys = ~clk_sys;
  // Cycles in which the device itself pulls the busy pin low
  always @(posedge clk_sys) if (busyLow) lowCyc <= lowCyc + 1;
  task automatic endSim;
    $display("errors %0d checks %0d", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : endSim
  task automatic chk(input logic [15:0] got, exp);
    testsRun++;
    if (got !== exp) begin
      numErrors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // A hung handshake ends the run rather than stalling it
  task automatic waitFor(input bit rsp);
    int n;
    n = 0;
    do @(posedge clk_sys); while ((rsp ? rspValid : cmdReady) !== 1'b1 && ++n < 2000);
    if (n >= 2000) begin
      numErrors++;
      $display("ERROR %0t timeout", $time);
      endSim();
    end
  endtask : waitFor
  task automatic cmd(input nvc_cmd_t op, input logic [20:0] a, input logic [15:0] d);
    cmdOp <= op;
    cmdAddr <= a;
    cmdWdata <= d;
    cmdValid <= 1'b1;
    waitFor(1'b0);
    cmdValid <= 1'b0;
    waitFor(1'b1);
  endtask : cmd
  task automatic tStoreRecall(input nvc_cmd_t op);
    cmd(NVC_CMD_WRITE, 21'h000021, 16'ha5c3);
    cmd(op, 21'h0, 16'h0);
    cmd(NVC_CMD_WRITE, 21'h000021, 16'h0f0f);
    cmd(NVC_CMD_RECALL, 21'h0, 16'h0);
    cmd(NVC_CMD_READ, 21'h000021, 16'h0);
    chk(rspRdata, 16'ha5c3);
  endtask : tStoreRecall
  task automatic tPinIdle;
    int n0;
    n0 = lowCyc;
    t0 = $time;
    cmd(NVC_CMD_PIN_STORE, 21'h0, 16'h0);
    chk(16'(lowCyc - n0), 16'h0);
    chk(16'(($time - t0) / 8 >= ST), 16'h1);
  endtask : tPinIdle
  // Supply dip after a write: the value seen after a later recall shows whether it was stored
  task automatic tPowerLoss(input logic [15:0] d, exp);
    cmd(NVC_CMD_WRITE, 21'h000042, d);
    supplyOk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    supplyOk <= 1'b1;
    cmd(NVC_CMD_WRITE, 21'h000042, 16'h0f0f);
    cmd(NVC_CMD_RECALL, 21'h0, 16'h0);
    cmd(NVC_CMD_READ, 21'h000042, 16'h0);
    chk(rspRdata, exp);
  endtask : tPowerLoss
  task automatic tAutoSave;
    cmd(NVC_CMD_AS_OFF, 21'h0, 16'h0);
    chk({15'h0, i_nvc_dev_model.autoOn}, 16'h0);
    tPowerLoss(16'h7788, 16'h3c5a);
    cmd(NVC_CMD_AS_ON, 21'h0, 16'h0);
    chk({15'h0, i_nvc_dev_model.autoOn}, 16'h1);
  endtask : tAutoSave
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t0 = $time;
    waitFor(1'b0);
    chk(16'(($time - t0) / 8 >= RT - 4), 16'h1);
    tStoreRecall(NVC_CMD_STORE);
    tStoreRecall(NVC_CMD_PIN_STORE);
    tPinIdle();
    tPowerLoss(16'h3c5a, 16'h3c5a);
    tAutoSave();
    endSim();
  end
endmodule : nvc_host_ctrl_test

// ==== nvc_pkg.sv ====
// Types for the nonvolatile SRAM store/recall host controller.
// Assumes nvc_defines.svh supplies the numeric constants.
`include "nvc_defines.svh"
package nvc_pkg;
  typedef enum logic [2:0] {
    NVC_CMD_STORE,
    NVC_CMD_RECALL,
    NVC_CMD_AS_OFF,
    NVC_CMD_AS_ON,
    NVC_CMD_PIN_STORE,
    NVC_CMD_READ,
    NVC_CMD_WRITE
  } nvc_cmd_t;
endpackage : nvc_pkg
